// ==== pkg/sdcr_pkg.sv ====
package sdcr_pkg;
  // Register offsets on the controller register port
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_TIM_ONE = 8'h10;
  localparam logic [7:0] OFS_TIM_TWO = 8'h14;
  // Configuration register field positions
  localparam int BIT_BANK_POS = 26;
  localparam int BIT_MOBILE = 25;
  localparam int BIT_BOOT_UNLOCK = 23;
  localparam int BIT_ENABLE = 16;
  localparam int BIT_TIM_UNLOCK = 15;
  localparam int BIT_NARROW = 14;
  localparam int CAS_MSB = 11;
  localparam int CAS_LSB = 9;
  localparam int LOW_MSB = 6;
  // Reset values
  localparam logic RST_ENABLE = 1'b1;
  localparam logic [2:0] RST_CAS = 3'h3;
  localparam logic [6:0] RST_LOW = 7'h20;
  localparam logic [31:0] RST_TIM = 32'h0000_0000;
  // Initialization sequence length
  localparam int unsigned INIT_TIME_US = 100;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned INIT_CYCLES_DEF = INIT_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {
    SDCR_IDLE = 2'b00,
    SDCR_RUN = 2'b01,
    SDCR_DONE = 2'b11
  } sdcr_state_e;
endpackage

// ==== pkg/sdcr_init_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface sdcr_init_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport seq (input start, output busy, output done);
endinterface
`default_nettype wire

// ==== verilog/sdcr_init_seq.sv ====
`timescale 1ns/10ps
`default_nettype none
module sdcr_init_seq import sdcr_pkg::*; #(
  parameter int unsigned INIT_CYCLES = INIT_CYCLES_DEF
) (
  input wire logic ref_clk, // Controller clock
  input wire logic rst_n, // Async reset, active low
  sdcr_init_if.seq initIf // Start, busy and done
);
  typedef struct packed {
    sdcr_state_e state;
    logic [31:0] cnt;
    logic busy;
    logic done;
  } sdcr_seq_s;

  localparam logic [31:0] LAST = 32'(INIT_CYCLES - 1);

  sdcr_seq_s s_q;
  sdcr_seq_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.state)
      SDCR_IDLE, SDCR_DONE: begin
        s_d.state = SDCR_IDLE;
        if (initIf.start) begin
          s_d.state = SDCR_RUN;
          s_d.cnt = 32'h0000_0000;
          s_d.busy = 1'b1;
        end
      end
      SDCR_RUN: begin
        // A new start restarts the whole sequence
        if (initIf.start) begin
          s_d.cnt = 32'h0000_0000;
        end else if (s_q.cnt == LAST) begin
          s_d.state = SDCR_DONE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 32'h0000_0001;
        end
      end
      default: begin
        s_d.state = SDCR_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{state: SDCR_IDLE, cnt: 32'h0000_0000, busy: 1'b0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign initIf.busy = s_q.busy;
  assign initIf.done = s_q.done;
endmodule // sdcr_init_seq
`default_nettype wire

// ==== verilog/sdcr_config_top.sv ====
// Overview of operation
// - Bank position bit needs enable unlock
// - Bank position picks standard or alternate bits
// - Mobile bit locked; mobile needs enable too
// - Lower-half write starts SDRAM initialization
// - Enable unlock gates the SDRAM enable bit
// - SDRAM enable bit writable only when unlocked
// - Enable low: no init, no refresh
// - Timing unlock gates latency and timing registers
// - Narrow select picks bus width, starts init
// - Latency codes 2h/3h, locked, starts init; any 3-bit code is stored
// - Then writes unlock zero with new values
`timescale 1ns/10ps
`default_nettype none
module sdcr_config_top import sdcr_pkg::*; #(
  parameter int unsigned INIT_CYCLES = INIT_CYCLES_DEF
) (
  input wire logic ref_clk, // Controller clock, 100 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic regWrEn, // Register write strobe
  input wire logic regRdEn, // Register read strobe
  input wire logic [7:0] regAddr, // Register byte offset
  input wire logic [31:0] regWrData, // Write word
  output logic [31:0] regRdData, // Read word
  output logic regRdValid, // Read word valid
  output logic bankBitPosition, // Alternate bank bit positions
  output logic mobileSdrMode, // Mobile SDR operation active
  output logic sdramEnable, // Full SDRAM operation
  output logic narrowBusSelect, // 16-bit data bus
  output logic [2:0] casLatency, // CAS latency code
  output logic [6:0] bankGeometry, // Bank, select and page fields
  output logic [31:0] timingRegOne, // First timing register
  output logic [31:0] timingRegTwo, // Second timing register
  output logic refreshEnable, // Refreshes may be issued
  output logic initBusy, // Initialization in progress
  output logic initDone // Initialization finished pulse
);
  typedef struct packed {
    logic bankPos;
    logic mobileEn;
    logic bootUnlock;
    logic sdram_enable;
    logic timing_write_unlock;
    logic narrow;
    logic [2:0] cas;
    logic [6:0] low;
    logic [31:0] timOne;
    logic [31:0] timTwo;
    logic [31:0] rdData;
    logic rdValid;
    logic mobileSdr;
    logic refreshEn;
    logic initStart;
    logic bootPend;
    logic initBusy;
    logic initDone;
  } sdcr_top_s;

  sdcr_top_s s_q;
  sdcr_top_s s_d;
  sdcr_init_if initIf ();

  sdcr_init_seq #(
    .INIT_CYCLES(INIT_CYCLES)
  ) u_init (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .initIf(initIf)
  );

  assign initIf.start = s_q.initStart;

  always_comb begin
    logic bootOpen;
    logic timOpen;
    logic cfgWr;
    bootOpen = s_q.bootUnlock;
    timOpen = s_q.timing_write_unlock | regWrData[BIT_TIM_UNLOCK];
    cfgWr = regWrEn && (regAddr == OFS_CONFIG);
    s_d = s_q;
    s_d.rdValid = regRdEn;
    s_d.initStart = 1'b0;
    s_d.bootPend = 1'b0;
    s_d.initBusy = initIf.busy;
    s_d.initDone = initIf.done;
    if (cfgWr) begin
      s_d.bootUnlock = regWrData[BIT_BOOT_UNLOCK];
      s_d.timing_write_unlock = regWrData[BIT_TIM_UNLOCK];
      s_d.narrow = regWrData[BIT_NARROW];
      s_d.low = regWrData[LOW_MSB:0];
      if (bootOpen) begin
        s_d.bankPos = regWrData[BIT_BANK_POS];
        s_d.mobileEn = regWrData[BIT_MOBILE];
        // enable bit gated, applied on relock write
        s_d.sdram_enable = regWrData[BIT_ENABLE];
      end
      if (timOpen) begin
        s_d.cas = regWrData[CAS_MSB:CAS_LSB];
      end
      // word write covers lower half, only when enabled
      s_d.initStart = s_d.sdram_enable;
    end
    if (s_q.bootPend && s_q.sdram_enable) begin
      s_d.initStart = 1'b1;
    end
    if (regWrEn && s_q.timing_write_unlock) begin
      if (regAddr == OFS_TIM_ONE) begin
        s_d.timOne = regWrData;
      end
      if (regAddr == OFS_TIM_TWO) begin
        s_d.timTwo = regWrData;
      end
    end
    s_d.rdData = 32'h0000_0000;
    if (regRdEn) begin
      case (regAddr)
        OFS_CONFIG: begin
          s_d.rdData[BIT_BANK_POS] = s_q.bankPos;
          s_d.rdData[BIT_MOBILE] = s_q.mobileEn;
          s_d.rdData[BIT_BOOT_UNLOCK] = s_q.bootUnlock;
          s_d.rdData[BIT_ENABLE] = s_q.sdram_enable;
          s_d.rdData[BIT_TIM_UNLOCK] = s_q.timing_write_unlock;
          s_d.rdData[BIT_NARROW] = s_q.narrow;
          s_d.rdData[CAS_MSB:CAS_LSB] = s_q.cas;
          s_d.rdData[LOW_MSB:0] = s_q.low;
        end
        OFS_TIM_ONE: s_d.rdData = s_q.timOne;
        OFS_TIM_TWO: s_d.rdData = s_q.timTwo;
        default: s_d.rdData = 32'h0000_0000;
      endcase
    end
    s_d.mobileSdr = s_d.mobileEn & s_d.sdram_enable;
    // no refresh from start request to init end
    s_d.refreshEn = s_d.sdram_enable & ~initIf.busy & ~s_d.initStart & ~s_q.initStart;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{
        bankPos: 1'b0, mobileEn: 1'b0, bootUnlock: 1'b0, sdram_enable: RST_ENABLE,
        timing_write_unlock: 1'b0, narrow: 1'b0, cas: RST_CAS, low: RST_LOW,
        timOne: RST_TIM, timTwo: RST_TIM, rdData: 32'h0000_0000,
        rdValid: 1'b0, mobileSdr: 1'b0, refreshEn: 1'b0, initStart: 1'b0,
        bootPend: 1'b1, initBusy: 1'b0, initDone: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  assign regRdValid = s_q.rdValid;
  assign bankBitPosition = s_q.bankPos;
  assign mobileSdrMode = s_q.mobileSdr;
  assign sdramEnable = s_q.sdram_enable;
  assign narrowBusSelect = s_q.narrow;
  assign casLatency = s_q.cas;
  assign bankGeometry = s_q.low;
  assign timingRegOne = s_q.timOne;
  assign timingRegTwo = s_q.timTwo;
  assign refreshEnable = s_q.refreshEn;
  assign initBusy = s_q.initBusy;
  assign initDone = s_q.initDone;
endmodule // sdcr_config_top
`default_nettype wire

// ==== verification/sdcr_sdram_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sdcr_sdram_model (
  input wire logic narrowBusSelect, // Width pick
  output logic [5:0] busWidth // Data bits used
);
  assign busWidth = narrowBusSelect ? 6'h10 : 6'h20;
endmodule // sdcr_sdram_model
`default_nettype wire

// ==== verification/sdcr_config_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module sdcr_config_checker import sdcr_pkg::*; #(
  parameter int unsigned INIT_CYCLES = INIT_CYCLES_DEF
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic regWrEn, // Write
  input wire logic regRdEn, // Read
  input wire logic [7:0] regAddr, // Offset
  input wire logic [31:0] regWrData, // Word
  input wire logic regRdValid, // Read valid
  input wire logic bankBitPosition, // Bank pos
  input wire logic mobileSdrMode, // Mobile
  input wire logic sdramEnable, // Enable
  input wire logic [2:0] casLatency, // Latency
  input wire logic [31:0] timingRegOne, // Timing
  input wire logic refreshEnable, // Refresh
  input wire logic initBusy // Busy
);
  logic cfgWr;
  logic bootUlk_q;
  logic timUlk_q;
  assign cfgWr = regWrEn && regAddr == OFS_CONFIG;
  // Stored unlock bits as the design sees them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bootUlk_q <= 1'b0;
      timUlk_q <= 1'b0;
    end else if (cfgWr) begin
      bootUlk_q <= regWrData[BIT_BOOT_UNLOCK];
      timUlk_q <= regWrData[BIT_TIM_UNLOCK];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rd_answer; regRdEn |=> regRdValid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_en_lock;
    cfgWr && !bootUlk_q |=> $stable(sdramEnable) && $stable(bankBitPosition);
  endproperty
  a_en_lock: assert property (p_en_lock) else $error("locked enable moved");
  property p_en_open;
    cfgWr && bootUlk_q |=> sdramEnable == $past(regWrData[BIT_ENABLE])
      && bankBitPosition == $past(regWrData[BIT_BANK_POS]);
  endproperty
  a_en_open: assert property (p_en_open) else $error("unlocked enable lost");
  property p_mobile; mobileSdrMode |-> sdramEnable; endproperty
  a_mobile: assert property (p_mobile) else $error("mobile without enable");
  property p_cas_lock;
    cfgWr && !timUlk_q && !regWrData[BIT_TIM_UNLOCK] |=> $stable(casLatency);
  endproperty
  a_cas_lock: assert property (p_cas_lock) else $error("locked latency moved");
  property p_cas_open;
    cfgWr && regWrData[BIT_TIM_UNLOCK] |=> casLatency == $past(regWrData[CAS_MSB:CAS_LSB]);
  endproperty
  a_cas_open: assert property (p_cas_open) else $error("latency lost");
  property p_tim_lock;
    regWrEn && regAddr == OFS_TIM_ONE && !timUlk_q |=> $stable(timingRegOne);
  endproperty
  a_tim_lock: assert property (p_tim_lock) else $error("locked timing moved");
  property p_init; cfgWr ##1 sdramEnable |-> ##2 initBusy; endproperty
  a_init: assert property (p_init) else $error("init not started");
  property p_refresh;
    initBusy || (!sdramEnable && !$past(sdramEnable)) |-> !refreshEnable;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh while off");
  property p_refresh_hold; cfgWr |=> !refreshEnable [*3]; endproperty
  a_refresh_hold: assert property (p_refresh_hold) else $error("refresh before init");
  c_unlock: cover property (cfgWr && bootUlk_q);
  c_init: cover property ($fell(initBusy));
  c_read: cover property (regRdValid);
endmodule // sdcr_config_checker
bind sdcr_config_top sdcr_config_checker #(.INIT_CYCLES(INIT_CYCLES)) i_sdcr_config_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
  .regWrData(regWrData), .regRdValid(regRdValid), .bankBitPosition(bankBitPosition),
  .mobileSdrMode(mobileSdrMode), .sdramEnable(sdramEnable), .casLatency(casLatency),
  .timingRegOne(timingRegOne), .refreshEnable(refreshEnable), .initBusy(initBusy));
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sdcr_pkg::*;
  logic ref_clk, rst_n, regWrEn, regRdEn, regRdValid, bankBitPosition, mobileSdrMode;
  logic sdramEnable, narrowBusSelect, refreshEnable, initBusy, initDone;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, timingRegOne, timingRegTwo, cfg, t1, t2, m;
  logic [2:0] casLatency;
  logic [6:0] bankGeometry;
  logic [5:0] busWidth;
  int miscompares, totalChecks, seed, i;
  logic [7:0] addrs [4] = '{OFS_CONFIG, OFS_TIM_ONE, OFS_TIM_TWO, 8'h0c};
  sdcr_config_top #(.INIT_CYCLES(20)) i_sdcr_config_top (.ref_clk(ref_clk), .rst_n(rst_n),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .bankBitPosition(bankBitPosition),
    .mobileSdrMode(mobileSdrMode), .sdramEnable(sdramEnable), .narrowBusSelect(narrowBusSelect),
    .casLatency(casLatency), .bankGeometry(bankGeometry), .timingRegOne(timingRegOne),
    .timingRegTwo(timingRegTwo), .refreshEnable(refreshEnable), .initBusy(initBusy),
    .initDone(initDone));
  sdcr_sdram_model i_sdcr_sdram_model (.narrowBusSelect(narrowBusSelect), .busWidth(busWidth));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge ref_clk);
    regWrEn = 1'b0;
    m = 32'h0080_C07F;
    if (cfg[23]) m = m | 32'h0601_0000;
    if (cfg[15] | d[15]) m = m | 32'h0000_0E00;
    if (a == OFS_TIM_ONE && cfg[15]) t1 = d;
    if (a == OFS_TIM_TWO && cfg[15]) t2 = d;
    if (a == OFS_CONFIG) cfg = (cfg & ~m) | (d & m);
    @(negedge ref_clk);
    chk("fields", {cfg[26], cfg[25] & cfg[16], cfg[16], cfg[14], cfg[11:9]},
      {bankBitPosition, mobileSdrMode, sdramEnable, narrowBusSelect, casLatency});
    chk("timing", t1, timingRegOne);
    chk("timing two", t2, timingRegTwo);
    chk("geometry", cfg[6:0], bankGeometry);
    chk("width", cfg[14] ? 32'h0000_0010 : 32'h0000_0020, busWidth);
  endtask
  task rd(input logic [7:0] a);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge ref_clk);
    regRdEn = 1'b0;
    // Answer stands for the cycle after the taking edge
    m = a == OFS_CONFIG ? cfg : a == OFS_TIM_ONE ? t1 : a == OFS_TIM_TWO ? t2 : 32'h0000_0000;
    chk("rvalid", 1, regRdValid);
    chk("rdata", m, regRdData);
    @(negedge ref_clk);
  endtask
  task waitDone;
    int k;
    for (k = 0; k < 100 && initDone !== 1'b1; k++) @(negedge ref_clk);
    chk("done", 1, initDone);
    chk("refresh", 1, refreshEnable);
  endtask
  task printVerdict;
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    printVerdict();
  end
  initial begin
    {rst_n, regWrEn, regRdEn, regAddr, regWrData, miscompares, totalChecks, t1, t2} = 0;
    seed = 36304;
    cfg = 32'h0001_0620;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    for (i = 0; i < 4; i++) rd(addrs[i]);
    waitDone();
    $display("test reset done");
    wr(OFS_CONFIG, 32'h0000_4000);
    wr(OFS_CONFIG, 32'h0080_0000);
    wr(OFS_CONFIG, 32'h0601_0000);
    rd(OFS_CONFIG);
    waitDone();
    $display("test unlock done");
    wr(OFS_TIM_ONE, 32'h1234_5678);
    wr(OFS_CONFIG, 32'h0000_8400);
    wr(OFS_TIM_ONE, 32'hA5A5_0F0F);
    wr(OFS_TIM_TWO, 32'h0F0F_A5A5);
    wr(OFS_CONFIG, 32'h0000_0600);
    wr(OFS_TIM_TWO, 32'h1111_2222);
    for (i = 0; i < 3; i++) rd(addrs[i]);
    waitDone();
    $display("test timing done");
    wr(OFS_CONFIG, 32'h0080_0000);
    waitDone();
    wr(OFS_CONFIG, 32'h0000_0000);
    repeat (30) @(negedge ref_clk);
    chk("idle", 0, {initBusy, refreshEnable});
    wr(OFS_CONFIG, 32'h0080_0000);
    wr(OFS_CONFIG, 32'h0001_0000);
    waitDone();
    $display("test disable done");
    for (i = 0; i < 40; i++) begin
      wr(addrs[$unsigned($random(seed)) % 4], $random(seed) & 32'h0680_CE7F);
      rd(regAddr);
    end
    $display("test random done");
    printVerdict();
  end
endmodule // tb_top
`default_nettype wire
